/* File: rtl/sltpg_pkg.sv */
/*
  constants, field layouts and carrier types of the serial link test pattern generator.
  assumes one lane/frame clock domain, with every input synchronous to it.
*/
package sltpg_pkg;
  localparam int NUM_LANES = 16;
  localparam int LANES_PER_SIDE = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_LINK_MODE = 4'h1;
  localparam logic [3:0] OFS_POWER = 4'h2;
  localparam logic [3:0] OFS_RAMP_K = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  // control and power fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_ENC64_BIT = 4;
  localparam int CTRL_FEC_BIT = 5;
  localparam int CTRL_DUAL_BIT = 6;
  localparam int CTRL_LINK_EN_BIT = 7;
  localparam int PWR_CFG_BIT = 0;
  localparam int PWR_CHA_BIT = 1;
  localparam int PWR_CHB_BIT = 2;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_LINK_MODE = 8'h00;
  localparam logic [2:0] RST_POWER = 3'h0;
  localparam logic [9:0] RST_RAMP_K = 10'h020;
  // pattern constants
  localparam logic [7:0] D215_OCTET = 8'hb5;
  localparam logic [7:0] ONES_OCTET = 8'hff;
  localparam logic [7:0] ZERO_OCTET = 8'h00;
  localparam logic [9:0] RAMP_K_WRAP = 10'h100;
  localparam logic [3:0] N12_TOP_NIB = 4'hf;
  localparam logic [3:0] N12_WORDS = 4'h5;
  localparam logic [3:0] N12_TAIL_NIB = 4'h0;
  localparam logic [2:0] N12_OCTETS = 3'h7;
  localparam logic [2:0] DDC_OCTETS = 3'h3;
  localparam logic [30:0] PRBS_SEED_BASE = 31'h2a5c_3e40;
  // link mode numbers with a special layout
  localparam logic [7:0] LM_N8_SINGLE = 8'h22;
  localparam logic [7:0] LM_N8_DUAL = 8'h23;
  localparam logic [7:0] LM_N12_SINGLE = 8'h20;
  localparam logic [7:0] LM_N12_DUAL = 8'h21;
  localparam logic [7:0] LM_DDC16_DUAL = 8'h38;

  typedef enum logic [3:0] {
    SLTPG_TP_NORMAL, SLTPG_TP_PRBS7, SLTPG_TP_PRBS9, SLTPG_TP_PRBS15, SLTPG_TP_PRBS23,
    SLTPG_TP_PRBS31, SLTPG_TP_CLOCK, SLTPG_TP_RAMP, SLTPG_TP_SHORT, SLTPG_TP_D215
  } sltpg_tp_t;

  typedef struct packed {
    logic drv_en;
    logic raw;
    logic [7:0] octet;
  } sltpg_lane_t;

  typedef struct packed {
    logic crc12_en;
    logic fec_en;
  } sltpg_sh_cfg_t;

  typedef struct packed {
    logic [15:0] ai;
    logic [15:0] aq;
    logic [15:0] bi;
    logic [15:0] bq;
  } sltpg_ddc_t;
endpackage

/* File: rtl/sltpg_top.sv */
/*
  test pattern generator and lane option control for the serial output lanes.
  assumes a link layer that consumes one octet per lane per clock, encodes and
  scrambles it unless raw is set, and reports alignment and serializer status.
*/
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
module sltpg_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [sltpg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sltpg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sltpg_pkg::DATA_W-1:0] reg_rdata,
  // pins
  input wire logic power_down_pin,
  // link layer status
  input wire logic ser_init_done,
  input wire logic ilas_done,
  input wire logic data_enc_state,
  input wire logic frame_start,
  input wire logic multiframe_start,
  // normal data
  input wire logic [sltpg_pkg::NUM_LANES-1:0][7:0] fmt_octet,
  input wire sltpg_pkg::sltpg_ddc_t ddc_word,
  // lane outputs
  output sltpg_pkg::sltpg_lane_t [sltpg_pkg::NUM_LANES-1:0] lane_out,
  output sltpg_pkg::sltpg_sh_cfg_t sh_cfg,
  output logic pattern_active
);
  import sltpg_pkg::*;

  logic [7:0] ctrl_ff;
  logic [7:0] link_mode_number_ff;
  logic [2:0] power_ff;
  logic [9:0] ramp_k_ff;
  logic [3:0] sel_ff;
  sltpg_tp_t tp_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [2:0] frm_oct_ff;
  logic par_ff;
  logic ramp_go_ff;
  logic [7:0] ramp_ff;
  logic [NUM_LANES-1:0][30:0] prbs_ff;
  logic [NUM_LANES-1:0][38:0] prbs_nxt;
  sltpg_lane_t [NUM_LANES-1:0] lane_ff;
  sltpg_sh_cfg_t sh_ff;
  logic active_ff;
  logic [2:0] oct_idx;
  logic nxt_par;
  logic [7:0] nxt_ramp;
  logic [7:0] ramp_top;
  logic pd_all;
  logic tt_go;
  logic link_en;
  logic enc64;
  logic dual;

  function automatic logic [4:0] lanes_for_mode(input logic [7:0] lm);
    case (lm)
      LM_N8_SINGLE, LM_N8_DUAL: lanes_for_mode = 5'h04;
      LM_N12_SINGLE, LM_N12_DUAL: lanes_for_mode = 5'h06;
      LM_DDC16_DUAL: lanes_for_mode = 5'h02;
      default: lanes_for_mode = 5'h10;
    endcase
  endfunction

  // one prbs step of eight bits; bit 0 of the state is the newest bit
  function automatic logic [38:0] prbs_step(input logic [30:0] s, input sltpg_tp_t tp);
    logic [30:0] st;
    logic [7:0] bits;
    logic b;
    int ta;
    int tb;
    st = s;
    bits = 8'h00;
    b = 1'b0;
    case (tp)
      SLTPG_TP_PRBS7: begin ta = 6; tb = 7; end
      SLTPG_TP_PRBS9: begin ta = 5; tb = 9; end
      SLTPG_TP_PRBS15: begin ta = 14; tb = 15; end
      SLTPG_TP_PRBS23: begin ta = 18; tb = 23; end
      default: begin ta = 28; tb = 31; end
    endcase
    for (int j = 7; j >= 0; j--) begin
      b = st[ta-1] ^ st[tb-1];
      st = {st[29:0], b};
      bits[j] = b;
    end
    prbs_step = {st, bits};
  endfunction

  function automatic logic [3:0] nib12(input logic [2:0] lane, input logic [3:0] n);
    logic [3:0] w;
    logic [3:0] p;
    w = n / 4'h3;
    p = n % 4'h3;
    if (w >= N12_WORDS) begin
      nib12 = N12_TAIL_NIB;
    end else if (p == 4'h0) begin
      nib12 = N12_TOP_NIB - {1'b0, lane};
    end else if (p == 4'h1) begin
      nib12 = {1'b0, lane};
    end else begin
      nib12 = w + 4'h1;
    end
  endfunction

  function automatic logic is_prbs(input sltpg_tp_t tp);
    is_prbs = (tp == SLTPG_TP_PRBS7) || (tp == SLTPG_TP_PRBS9) || (tp == SLTPG_TP_PRBS15) ||
      (tp == SLTPG_TP_PRBS23) || (tp == SLTPG_TP_PRBS31);
  endfunction

  assign link_en = ctrl_ff[CTRL_LINK_EN_BIT];
  assign enc64 = ctrl_ff[CTRL_ENC64_BIT];
  assign dual = ctrl_ff[CTRL_DUAL_BIT];
  assign pd_all = power_down_pin | power_ff[PWR_CFG_BIT];

  // register writes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_ff <= RST_CTRL;
      link_mode_number_ff <= RST_LINK_MODE;
      power_ff <= RST_POWER;
      ramp_k_ff <= RST_RAMP_K;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: ctrl_ff <= reg_wdata[7:0];
        OFS_LINK_MODE: link_mode_number_ff <= reg_wdata[7:0];
        OFS_POWER: power_ff <= reg_wdata[2:0];
        OFS_RAMP_K: ramp_k_ff <= reg_wdata[9:0];
        default: ;
      endcase
    end
  end

  // the pattern in use only follows the written code while the link is off,
  // so a careless write cannot tear a running link
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sel_ff <= 4'h0;
      tp_ff <= SLTPG_TP_NORMAL;
    end else begin
      sel_ff <= ctrl_ff[CTRL_SEL_LSB+3:CTRL_SEL_LSB];
      if (!link_en) begin
        if (sel_ff <= 4'(SLTPG_TP_D215)) begin
          tp_ff <= sltpg_tp_t'(sel_ff);
        end else begin
          tp_ff <= SLTPG_TP_NORMAL;
        end
      end
    end
  end

  // register reads, data in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: rdata_ff <= {8'h00, ctrl_ff};
        OFS_LINK_MODE: rdata_ff <= {8'h00, link_mode_number_ff};
        OFS_POWER: rdata_ff <= {13'h0000, power_ff};
        OFS_RAMP_K: rdata_ff <= {6'h00, ramp_k_ff};
        OFS_STATUS: rdata_ff <= {3'h0, lanes_for_mode(link_mode_number_ff), 2'h0, tp_ff, active_ff, pd_all};
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  // only the 12-bit crc exists; no 3-bit variant is offered
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sh_ff <= '{crc12_en: 1'b1, fec_en: 1'b0};
    end else begin
      sh_ff.crc12_en <= ~ctrl_ff[CTRL_FEC_BIT];
      sh_ff.fec_en <= ctrl_ff[CTRL_FEC_BIT];
    end
  end

  // frame position and frame parity
  always_comb begin
    oct_idx = frame_start ? 3'h0 : frm_oct_ff;
    nxt_par = frame_start ? ~par_ff : par_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      frm_oct_ff <= 3'h0;
      par_ff <= 1'b1;
    end else begin
      frm_oct_ff <= oct_idx + 3'h1;
      par_ff <= nxt_par;
    end
  end

  // the short pattern runs once aligned and in data state (8b/10b), or once serializers are up (64b/66b)
  assign tt_go = enc64 ? ser_init_done : (ilas_done & data_enc_state);

  // ramp counter; k of 256 and above wraps at 0xff
  always_comb begin
    ramp_top = (ramp_k_ff < RAMP_K_WRAP) ? 8'(ramp_k_ff - 10'h001) : ONES_OCTET;
    if (multiframe_start || !ramp_go_ff) begin
      nxt_ramp = ZERO_OCTET;
    end else if (ramp_ff >= ramp_top) begin
      nxt_ramp = ZERO_OCTET;
    end else begin
      nxt_ramp = ramp_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ramp_go_ff <= 1'b0;
      ramp_ff <= ZERO_OCTET;
    end else begin
      if (tp_ff != SLTPG_TP_RAMP) begin
        ramp_go_ff <= 1'b0;
      end else if (enc64 ? ser_init_done : ilas_done) begin
        ramp_go_ff <= 1'b1;
      end
      ramp_ff <= nxt_ramp;
    end
  end

  always_comb begin
    for (int l = 0; l < NUM_LANES; l++) prbs_nxt[l] = prbs_step(prbs_ff[l], tp_ff);
  end

  // per-lane prbs state; seeds differ in the low five bits so every length is distinct
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int l = 0; l < NUM_LANES; l++) begin
        prbs_ff[l] <= PRBS_SEED_BASE | 31'(l + 1);
      end
    end else begin
      for (int l = 0; l < NUM_LANES; l++) begin
        if (is_prbs(tp_ff)) begin
          prbs_ff[l] <= prbs_nxt[l][38:8];
        end else begin
          prbs_ff[l] <= PRBS_SEED_BASE | 31'(l + 1);
        end
      end
    end
  end

  // lane octets and driver enables
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lane_ff <= '0;
      active_ff <= 1'b0;
    end else begin
      active_ff <= (tp_ff != SLTPG_TP_NORMAL);
      for (int l = 0; l < NUM_LANES; l++) begin
        // driver count depends on the link mode, the dual bit, the power-down pin and bits, never on the pattern
        lane_ff[l].drv_en <= !pd_all && (5'(l % LANES_PER_SIDE) < (lanes_for_mode(link_mode_number_ff) >> 1)) &&
          !(dual && power_ff[(l < LANES_PER_SIDE) ? PWR_CHA_BIT : PWR_CHB_BIT]);
        lane_ff[l].raw <= is_prbs(tp_ff) || (tp_ff == SLTPG_TP_CLOCK);
        case (tp_ff)
          SLTPG_TP_PRBS7, SLTPG_TP_PRBS9, SLTPG_TP_PRBS15, SLTPG_TP_PRBS23, SLTPG_TP_PRBS31: begin
            lane_ff[l].octet <= prbs_nxt[l][7:0];
          end
          SLTPG_TP_CLOCK: begin
            lane_ff[l].octet <= (lane_ff[l].octet == ONES_OCTET) ? ZERO_OCTET : ONES_OCTET;
          end
          SLTPG_TP_RAMP: begin
            lane_ff[l].octet <= nxt_ramp;
          end
          SLTPG_TP_SHORT: begin
            // short pattern in every link mode; idle octets until the link allows it
            if (!tt_go) begin
              lane_ff[l].octet <= ZERO_OCTET;
            end else if ((link_mode_number_ff == LM_N12_SINGLE) || (link_mode_number_ff == LM_N12_DUAL)) begin
              lane_ff[l].octet <= {nib12(3'(l % LANES_PER_SIDE), {oct_idx, 1'b0}),
                nib12(3'(l % LANES_PER_SIDE), {oct_idx, 1'b1})};
            end else begin
              lane_ff[l].octet <= nxt_par ? (ONES_OCTET - 8'(l % 4)) : 8'(l % 4);
            end
          end
          SLTPG_TP_D215: begin
            lane_ff[l].octet <= D215_OCTET;
          end
          default: begin
            if ((link_mode_number_ff == LM_DDC16_DUAL) && ((l == 0) || (l == LANES_PER_SIDE))) begin
              // channel a i then q on the first lane of side a, channel b on side b, high octet first
              case (oct_idx[1:0] & DDC_OCTETS[1:0])
                2'h0: lane_ff[l].octet <= (l == 0) ? ddc_word.ai[15:8] : ddc_word.bi[15:8];
                2'h1: lane_ff[l].octet <= (l == 0) ? ddc_word.ai[7:0] : ddc_word.bi[7:0];
                2'h2: lane_ff[l].octet <= (l == 0) ? ddc_word.aq[15:8] : ddc_word.bq[15:8];
                default: lane_ff[l].octet <= (l == 0) ? ddc_word.aq[7:0] : ddc_word.bq[7:0];
              endcase
            end else begin
              lane_ff[l].octet <= fmt_octet[l];
            end
          end
        endcase
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign lane_out = lane_ff;
  assign sh_cfg = sh_ff;
  assign pattern_active = active_ff;

  // checks
  function automatic logic prbs7_ok(input logic [15:0] w);
    prbs7_ok = 1'b1;
    for (int p = 0; p < 8; p++) begin
      if (w[p] != (w[p+6] ^ w[p+7])) begin
        prbs7_ok = 1'b0;
      end
    end
  endfunction

  a_pin_pd_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    power_down_pin |=> (lane_out[0].drv_en == 1'b0) && (lane_out[15].drv_en == 1'b0))
    else $error("driver enabled during pin power-down");
  a_cfg_pd_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    power_ff[PWR_CFG_BIT] |=> !lane_out[1].drv_en && !lane_out[9].drv_en)
    else $error("driver enabled during config power-down");
  a_chan_b_pd: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (dual && power_ff[PWR_CHB_BIT] && !power_ff[PWR_CHA_BIT] && !pd_all && (link_mode_number_ff == LM_N8_DUAL))
    |=> lane_out[0].drv_en && !lane_out[8].drv_en)
    else $error("channel power-down not per channel");
  a_lane_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!pd_all && (power_ff[2:1] == 2'h0)) ##1 $stable(link_mode_number_ff) |->
    ($countones({lane_out[15].drv_en, lane_out[14].drv_en, lane_out[13].drv_en, lane_out[12].drv_en,
      lane_out[11].drv_en, lane_out[10].drv_en, lane_out[9].drv_en, lane_out[8].drv_en,
      lane_out[7].drv_en, lane_out[6].drv_en, lane_out[5].drv_en, lane_out[4].drv_en,
      lane_out[3].drv_en, lane_out[2].drv_en, lane_out[1].drv_en, lane_out[0].drv_en})
      == int'(lanes_for_mode(link_mode_number_ff))))
    else $error("powered lane count differs from link mode");
  a_prbs_raw: assert property (@(posedge clk_sys) disable iff (sys_rst)
    is_prbs(tp_ff) |=> lane_out[3].raw)
    else $error("prbs octet not marked raw");
  a_prbs7_rec: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (tp_ff == SLTPG_TP_PRBS7) [*3] |=> prbs7_ok({$past(lane_ff[0].octet), lane_ff[0].octet}))
    else $error("prbs7 recurrence broken");
  a_prbs_seeds: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !is_prbs(tp_ff) |=> (prbs_ff[0][4:0] != prbs_ff[1][4:0]) && (prbs_ff[0] != 31'h0))
    else $error("lane prbs seeds not distinct");
  a_clock_alt: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (tp_ff == SLTPG_TP_CLOCK) [*2] |=> (lane_out[0].octet == ~$past(lane_out[0].octet)) && lane_out[0].raw)
    else $error("clock pattern does not alternate");
  a_ramp_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ramp_go_ff && !multiframe_start && (ramp_ff < ramp_top)) |=> (ramp_ff == $past(ramp_ff) + 8'h01))
    else $error("ramp did not count up");
  a_ramp_same: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (tp_ff == SLTPG_TP_RAMP) |=> (lane_out[0].octet == lane_out[7].octet) && !lane_out[7].raw)
    else $error("ramp octets differ between lanes");
  a_n8_lane1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ((tp_ff == SLTPG_TP_SHORT) && tt_go && (link_mode_number_ff == LM_N8_SINGLE) && !nxt_par)
    |=> lane_out[1].octet == 8'h01)
    else $error("n8 short pattern wrong on lane 1");
  a_sh_mode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 (sh_cfg.fec_en == $past(ctrl_ff[CTRL_FEC_BIT])) && (sh_cfg.crc12_en != sh_cfg.fec_en))
    else $error("sync header mode mismatch");
  a_bad_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!link_en && (sel_ff > 4'(SLTPG_TP_D215))) |=> tp_ff == SLTPG_TP_NORMAL)
    else $error("unknown code left normal operation");
  c_prbs31: cover property (@(posedge clk_sys) disable iff (sys_rst) (tp_ff == SLTPG_TP_PRBS31) [*4]);
  c_ramp_wrap: cover property (@(posedge clk_sys) disable iff (sys_rst) ramp_go_ff && (ramp_ff == ramp_top));
  c_short_n12: cover property (@(posedge clk_sys) disable iff (sys_rst)
    (tp_ff == SLTPG_TP_SHORT) && tt_go && (link_mode_number_ff == LM_N12_SINGLE));
  c_chan_pd: cover property (@(posedge clk_sys) disable iff (sys_rst) dual && power_ff[PWR_CHA_BIT] && !pd_all);
endmodule

/* File: tb/sltpg_link_model.sv */
/*
  far-side link model: serializer init, ila and data-state levels, frame and
  multiframe pulses. assumes the block's clock and reset; lane 0 drivers gate the link.
*/
`timescale 1ns/10ps
module sltpg_link_model #(
  parameter int INIT_DLY = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // bench control
  input wire logic link_up,
  input wire logic [3:0] frame_len,
  input wire logic [9:0] mf_len,
  // lanes from the block
  input wire sltpg_pkg::sltpg_lane_t [sltpg_pkg::NUM_LANES-1:0] lane_out,
  // status to the block
  output logic ser_init_done,
  output logic ilas_done,
  output logic data_enc_state,
  output logic frame_start,
  output logic multiframe_start
);
  import sltpg_pkg::*;
  logic [7:0] up_cnt_ff;
  logic [3:0] f_cnt_ff;
  logic [9:0] mf_cnt_ff;
  // a dark lane 0 driver drops the link; it is rebuilt from scratch afterwards
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !link_up || !lane_out[0].drv_en) begin
      up_cnt_ff <= 8'h00;
    end else if (up_cnt_ff != 8'hff) begin
      up_cnt_ff <= up_cnt_ff + 8'h01;
    end
  end
  assign ser_init_done = up_cnt_ff >= 8'(INIT_DLY);
  // ila lags serializer init, so 8b/10b starts later than 64b/66b
  assign ilas_done = up_cnt_ff >= 8'(INIT_DLY + 3);
  assign data_enc_state = ilas_done;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      f_cnt_ff <= 4'h0;
      mf_cnt_ff <= 10'h000;
      frame_start <= 1'b0;
      multiframe_start <= 1'b0;
    end else begin
      f_cnt_ff <= (f_cnt_ff + 4'h1 >= frame_len) ? 4'h0 : f_cnt_ff + 4'h1;
      mf_cnt_ff <= (mf_cnt_ff + 10'h001 >= mf_len) ? 10'h000 : mf_cnt_ff + 10'h001;
      frame_start <= f_cnt_ff == 4'h0;
      multiframe_start <= mf_cnt_ff == 10'h000;
    end
  end
endmodule

/* File: tb/tb.sv */
/*
  self-checking bench of the test pattern generator: register port tasks, one task per scenario.
  assumes the link model in tb/ and the design package.
*/
`timescale 1ns/10ps
module tb;
  import sltpg_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic power_down_pin = 1'b0;
  logic link_up = 1'b0;
  logic [3:0] frame_len = 4'h2;
  logic ser_init_done, ilas_done, data_enc_state, frame_start, multiframe_start;
  logic [NUM_LANES-1:0][7:0] fmt_octet;
  sltpg_ddc_t ddc_word = '{16'h9a1b, 16'h2c3d, 16'h4e5f, 16'h6071};
  sltpg_lane_t [NUM_LANES-1:0] lane_out;
  sltpg_sh_cfg_t sh_cfg;
  logic pattern_active;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 clk_sys = ~clk_sys;
  sltpg_top sltpg_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_down_pin(power_down_pin),
    .ser_init_done(ser_init_done), .ilas_done(ilas_done), .data_enc_state(data_enc_state),
    .frame_start(frame_start), .multiframe_start(multiframe_start), .fmt_octet(fmt_octet),
    .ddc_word(ddc_word), .lane_out(lane_out), .sh_cfg(sh_cfg), .pattern_active(pattern_active));
  sltpg_link_model sltpg_link_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .link_up(link_up),
    .frame_len(frame_len), .mf_len(10'h004), .lane_out(lane_out), .ser_init_done(ser_init_done),
    .ilas_done(ilas_done), .data_enc_state(data_enc_state), .frame_start(frame_start),
    .multiframe_start(multiframe_start));
  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  function automatic logic [15:0] drv();
    for (int l = 0; l < NUM_LANES; l++) drv[l] = lane_out[l].drv_en;
  endfunction
  function automatic logic [3:0] nib(input int i, input int n);
    if (n == 15) return 4'h0;
    if (n % 3 == 0) return 4'(15 - i);
    if (n % 3 == 1) return 4'(i);
    return 4'(n / 3 + 1);
  endfunction
  task automatic t_regs();
    logic [15:0] d;
    rd(OFS_CTRL, d);
    check(d, 16'(RST_CTRL));
    rd(OFS_LINK_MODE, d);
    check(d, 16'(RST_LINK_MODE));
    rd(OFS_POWER, d);
    check(d, 16'(RST_POWER));
    rd(OFS_RAMP_K, d);
    check(d, 16'(RST_RAMP_K));
    rd(4'h9, d);
    check(d, 16'h0000);
    check(sh_cfg, 2'b10);
    wr(OFS_CTRL, 16'h0030);
    tick(3);
    check(sh_cfg, 2'b01);
    wr(OFS_CTRL, 16'h0010);
    tick(3);
    check(sh_cfg, 2'b10);
  endtask
  task automatic t_power();
    logic [15:0] d;
    wr(OFS_LINK_MODE, 16'h0023);
    tick(3);
    check(drv(), 16'h0303);
    rd(OFS_STATUS, d);
    check(d[12:8], 5'h04);
    @(posedge clk_sys);
    power_down_pin <= 1'b1;
    tick(2);
    check(drv(), 16'h0000);
    @(posedge clk_sys);
    power_down_pin <= 1'b0;
    wr(OFS_POWER, 16'h0001);
    tick(2);
    check(drv(), 16'h0000);
    wr(OFS_CTRL, 16'h0040);
    wr(OFS_POWER, 16'h0002);
    tick(2);
    check(drv(), 16'h0300);
    wr(OFS_POWER, 16'h0004);
    tick(2);
    check(drv(), 16'h0003);
    wr(OFS_CTRL, 16'h0000);
    tick(2);
    check(drv(), 16'h0303);
    wr(OFS_POWER, 16'h0000);
  endtask
  task automatic t_prbs(input logic [3:0] code, input int ta, input int tb2);
    logic [0:63] s0;
    logic [0:63] s1;
    int bad;
    bad = 0;
    wr(OFS_CTRL, {12'h000, code});
    tick(4);
    for (int j = 0; j < 8; j++) begin
      s0[8*j +: 8] = lane_out[0].octet;
      s1[8*j +: 8] = lane_out[1].octet;
      bad += int'(lane_out[0].raw !== 1'b1);
      tick(1);
    end
    for (int n = tb2; n < 64; n++) bad += int'(s0[n] !== (s0[n-ta] ^ s0[n-tb2]));
    check(bad, 0);
    check({s0 !== 64'h0, s0 !== s1}, 2'b11);
    check(drv(), 16'h0303);
  endtask
  task automatic t_clock();
    logic [7:0] o1;
    wr(OFS_CTRL, 16'h0006);
    tick(4);
    o1 = lane_out[3].octet;
    tick(1);
    check({o1, lane_out[3].octet} === 16'hff00 || {o1, lane_out[3].octet} === 16'h00ff, 1'b1);
    check(lane_out[3].raw, 1'b1);
  endtask
  task automatic t_ramp();
    logic [7:0] o1;
    int bad;
    bad = 0;
    wr(OFS_LINK_MODE, 16'h0000);
    wr(OFS_RAMP_K, 16'h0004);
    wr(OFS_CTRL, 16'h0017);
    tick(4);
    o1 = lane_out[0].octet;
    tick(1);
    check({o1, lane_out[0].octet}, 16'h0000);
    @(posedge clk_sys);
    link_up <= 1'b1;
    tick(16);
    for (int j = 0; j < 8; j++) begin
      o1 = lane_out[0].octet;
      for (int l = 1; l < NUM_LANES; l++) bad += int'(lane_out[l] !== lane_out[0]);
      tick(1);
      bad += int'(lane_out[0].octet !== ((o1 + 8'h01) & 8'h03));
    end
    check(bad, 0);
    check(lane_out[0].raw, 1'b0);
    @(posedge clk_sys);
    link_up <= 1'b0;
  endtask
  task automatic t_short();
    logic [7:0] a [NUM_LANES];
    int bad;
    bad = 0;
    wr(OFS_LINK_MODE, 16'h0022);
    wr(OFS_CTRL, 16'h0008);
    tick(6);
    check(lane_out[1].octet, 8'h00);
    @(posedge clk_sys);
    link_up <= 1'b1;
    tick(12);
    for (int l = 0; l < NUM_LANES; l++) a[l] = lane_out[l].octet;
    tick(2);
    for (int l = 0; l < NUM_LANES; l++) begin
      if (l % 8 < 4) begin
        bad += int'({a[l], lane_out[l].octet} !== {8'(l % 4), 8'hff - 8'(l % 4)}
          && {a[l], lane_out[l].octet} !== {8'hff - 8'(l % 4), 8'(l % 4)});
      end
    end
    check(bad, 0);
    @(posedge clk_sys);
    frame_len <= 4'h8;
    wr(OFS_LINK_MODE, 16'h0020);
    tick(20);
    for (int w = 0; w < 10 && frame_start !== 1'b1; w++) tick(1);
    tick(1);
    for (int o = 0; o < 8; o++) begin
      bad += int'(lane_out[2].octet !== {nib(2, 2 * o), nib(2, 2 * o + 1)});
      bad += int'(lane_out[10].octet !== {nib(2, 2 * o), nib(2, 2 * o + 1)});
      tick(1);
    end
    check(bad, 0);
    check(drv(), 16'h0707);
  endtask
  task automatic t_misc();
    logic [31:0] s;
    logic [31:0] t;
    logic [15:0] d;
    wr(OFS_CTRL, 16'h0009);
    tick(4);
    check({lane_out[5].raw, lane_out[5].octet}, {1'b0, D215_OCTET});
    // link enabled with the same code: the effective pattern must hold
    wr(OFS_CTRL, 16'h0089);
    tick(3);
    rd(OFS_STATUS, d);
    check(d[5:1], 5'h13);
    wr(OFS_CTRL, 16'h0009);
    wr(OFS_CTRL, 16'h000c);
    tick(4);
    check({pattern_active, lane_out[2].octet}, {1'b0, 8'h42});
    wr(OFS_LINK_MODE, 16'h0038);
    tick(3);
    for (int w = 0; w < 4 && lane_out[0].octet !== 8'h9a; w++) tick(1);
    for (int j = 0; j < 4; j++) begin
      s[31-8*j -: 8] = lane_out[0].octet;
      t[31-8*j -: 8] = lane_out[8].octet;
      tick(1);
    end
    check({s, t}, {ddc_word.ai, ddc_word.aq, ddc_word.bi, ddc_word.bq});
    check(drv(), 16'h0101);
  endtask
  initial begin
    for (int l = 0; l < NUM_LANES; l++) fmt_octet[l] = 8'h40 + 8'(l);
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_power();
    // link stays disabled whenever the select changes
    // calibration is not modelled; a host pairing it with power-down sets the converter-off field to 1
    t_prbs(4'h1, 6, 7);
    t_prbs(4'h2, 5, 9);
    t_prbs(4'h3, 14, 15);
    t_prbs(4'h4, 18, 23);
    t_prbs(4'h5, 28, 31);
    t_clock();
    t_ramp();
    t_short();
    t_misc();
    end_of_test();
  end
endmodule
